// ### frame_ctrl_pkg.sv
// constants for the frame handling, checksum, acknowledge and source-match control block
`default_nettype none
package frame_ctrl_pkg;
   // ----------------------------------------
   // register indices (byte address = index * 4)
   // ----------------------------------------
   localparam int ADDR_W = 18;
   localparam logic [15:0] IDX_SHORT_LO = 16'h6183;
   localparam logic [15:0] IDX_SHORT_MID = 16'h6184;
   localparam logic [15:0] IDX_SHORT_HI = 16'h6185;
   localparam logic [15:0] IDX_EXT_LO = 16'h6186;
   localparam logic [15:0] IDX_EXT_MID = 16'h6187;
   localparam logic [15:0] IDX_EXT_HI = 16'h6188;
   localparam logic [15:0] IDX_FRAME_CTRL = 16'h6189;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'h6190;
   localparam logic [15:0] IDX_IRQ_ENABLE = 16'h6191;
   localparam logic [15:0] IDX_IRQ_CLEAR = 16'h6192;
   localparam logic [15:0] IDX_SHORT_PEND = 16'h6193;
   localparam logic [15:0] IDX_EXT_PEND = 16'h6194;
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int APPEND_BIT = 7;
   localparam int AUTO_CHECKSUM_ENABLE_BIT = 6;
   localparam int AUTOACK_BIT = 5;
   localparam logic [7:0] FRAME_CTRL_RESET = 8'h40;
   localparam int NUM_EV = 4;
   localparam int EV_RX_DONE = 0;
   localparam int EV_TX_DONE = 1;
   localparam int EV_TX_UNDERFLOW = 2;
   localparam int EV_ACK_SENT = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------
   // checksum and match index
   // ----------------------------------------
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;
   localparam logic [8:0] FCS_BYTES = 9'h002;
   localparam logic [6:0] NO_MATCH = 7'h7F;
   localparam logic [6:0] EXT_INDEX_BASE = 7'h20;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int SYMBOL_NS = 16000;
   localparam int ACK_SYMBOLS = 12;
   localparam int ACK_DELAY_CYCLES = (ACK_SYMBOLS * SYMBOL_NS) / CLK_PERIOD_NS;
   typedef enum {TX_PASS, TX_CRC_LO, TX_CRC_HI} tx_state_type;
endpackage : frame_ctrl_pkg
`default_nettype wire

// ### frame_crc_ack_srcmatch_ctrl.sv
// frame checksum, status append, auto acknowledge and source-match enable control
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - 24-bit short-entry enable over three registers
// - 24-bit word enables 12 extended entries
// - extended writes: only even bits stored
// - extended reads: entry shows on both bits
// - append select ignored without auto checksum
// - select 0: strength, crc-good, correlation appended
// - select 1: strength, crc-good, match index
// - transmit appends generated CRC-16 when enabled
// - receive checks CRC, stores status word instead
// - checksum off: received CRC bytes stored unchanged
// - checksum setting leaves acknowledgements unchanged
// - auto acknowledge twelve symbols after good frame
// - pending match needs address and pending enable
module frame_crc_ack_srcmatch_ctrl
   import frame_ctrl_pkg::*;
#(
   parameter int ACK_DELAY = ACK_DELAY_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq,
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   input wire logic rxLast,
   input wire logic [7:0] rssi,
   input wire logic [6:0] correlation,
   input wire logic addrAccepted,
   input wire logic ackRequested,
   output logic [7:0] queueData,
   output logic queueValid,
   input wire logic [23:0] shortHit,
   input wire logic [11:0] extHit,
   output logic [6:0] matchedEntryIndex,
   output logic pendingMatch,
   input wire logic [7:0] txBufData,
   input wire logic txBufValid,
   input wire logic txBufLast,
   output logic txBufReady,
   output logic [7:0] airData,
   output logic airValid,
   output logic txUnderflow,
   output logic ackSend
);
   localparam int ACK_W = $clog2(ACK_DELAY + 1);

   function automatic logic [15:0] crcNext(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c;
      for (int i = 0; i < 8; i++) begin
         x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction : crcNext

   // short entries win over extended, lowest entry first
   function automatic logic [6:0] firstHit(input logic [23:0] s, input logic [11:0] e);
      logic [6:0] r;
      r = NO_MATCH;
      for (int i = 11; i >= 0; i--) begin
         if (e[i]) r = EXT_INDEX_BASE | 7'(i);
      end
      for (int i = 23; i >= 0; i--) begin
         if (s[i]) r = 7'(i);
      end
      return r;
   endfunction : firstHit

   function automatic logic [23:0] merge24(input logic [23:0] o, input logic [31:0] d, input logic [3:0] s);
      logic [23:0] r;
      r = o;
      for (int i = 0; i < 3; i++) begin
         if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
      end
      return r;
   endfunction : merge24

   logic [23:0] shortEn_r;
   logic [11:0] extEn_r;
   logic [23:0] shortPend_r;
   logic [11:0] extPend_r;
   logic [2:0] ctrl_r;
   logic [NUM_EV-1:0] irqStatus_r;
   logic [NUM_EV-1:0] irqEnable_r;
   logic awHeld_r;
   logic wHeld_r;
   logic [ADDR_W-1:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic [15:0] wrIdx;
   logic [15:0] rdIdx;
   logic wrHit;
   logic rdHit;
   logic doWrite;
   logic lane0;
   logic [31:0] rdVal;
   logic [23:0] extRd;
   logic appendSel;
   logic auto_checksum_enable;
   logic autoAck;

   assign appendSel = ctrl_r[2];
   assign auto_checksum_enable = ctrl_r[1];
   assign autoAck = ctrl_r[0];

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   assign awready = !awHeld_r && !bvalid;
   assign wready = !wHeld_r && !bvalid;
   assign arready = !rvalid;
   assign doWrite = awHeld_r && wHeld_r && !bvalid;
   assign wrIdx = awAddr_r[ADDR_W-1:2];
   assign rdIdx = araddr[ADDR_W-1:2];
   assign lane0 = wStrb_r[0];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= '0;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awHeld_r <= 1'b1;
            awAddr_r <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld_r <= 1'b1;
            wData_r <= wdata;
            wStrb_r <= wstrb;
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      case (wrIdx)
         IDX_SHORT_LO, IDX_SHORT_MID, IDX_SHORT_HI, IDX_EXT_LO, IDX_EXT_MID, IDX_EXT_HI,
         IDX_FRAME_CTRL, IDX_IRQ_ENABLE, IDX_IRQ_CLEAR, IDX_SHORT_PEND, IDX_EXT_PEND: wrHit = 1'b1;
         default: wrHit = 1'b0;
      endcase
   end

   always_comb begin
      for (int i = 0; i < 24; i++) begin
         extRd[i] = extEn_r[i/2];
      end
   end

   always_comb begin
      rdHit = 1'b1;
      rdVal = 32'h0000_0000;
      case (rdIdx)
         IDX_SHORT_LO: rdVal[7:0] = shortEn_r[7:0];
         IDX_SHORT_MID: rdVal[7:0] = shortEn_r[15:8];
         IDX_SHORT_HI: rdVal[7:0] = shortEn_r[23:16];
         IDX_EXT_LO: rdVal[7:0] = extRd[7:0];
         IDX_EXT_MID: rdVal[7:0] = extRd[15:8];
         IDX_EXT_HI: rdVal[7:0] = extRd[23:16];
         IDX_FRAME_CTRL: rdVal[7:5] = ctrl_r;
         IDX_IRQ_STATUS: rdVal[NUM_EV-1:0] = irqStatus_r;
         IDX_IRQ_ENABLE: rdVal[NUM_EV-1:0] = irqEnable_r;
         IDX_IRQ_CLEAR: rdVal = 32'h0000_0000;
         IDX_SHORT_PEND: rdVal[23:0] = shortPend_r;
         IDX_EXT_PEND: rdVal[11:0] = extPend_r;
         default: rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata <= rdVal;
         rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         shortEn_r <= 24'h00_0000;
         extEn_r <= 12'h000;
         ctrl_r <= FRAME_CTRL_RESET[7:5];
         irqEnable_r <= '0;
         shortPend_r <= 24'h00_0000;
         extPend_r <= 12'h000;
      end else if (doWrite) begin
         case (wrIdx)
            IDX_SHORT_LO: if (lane0) shortEn_r[7:0] <= wData_r[7:0];
            IDX_SHORT_MID: if (lane0) shortEn_r[15:8] <= wData_r[7:0];
            IDX_SHORT_HI: if (lane0) shortEn_r[23:16] <= wData_r[7:0];
            IDX_EXT_LO: if (lane0) extEn_r[3:0] <= {wData_r[6], wData_r[4], wData_r[2], wData_r[0]};
            IDX_EXT_MID: if (lane0) extEn_r[7:4] <= {wData_r[6], wData_r[4], wData_r[2], wData_r[0]};
            IDX_EXT_HI: if (lane0) extEn_r[11:8] <= {wData_r[6], wData_r[4], wData_r[2], wData_r[0]};
            IDX_FRAME_CTRL: if (lane0) ctrl_r <= wData_r[APPEND_BIT:AUTOACK_BIT];
            IDX_IRQ_ENABLE: if (lane0) irqEnable_r <= wData_r[NUM_EV-1:0];
            IDX_SHORT_PEND: shortPend_r <= merge24(shortPend_r, wData_r, wStrb_r);
            IDX_EXT_PEND: extPend_r <= 12'(merge24({12'h000, extPend_r}, wData_r, wStrb_r));
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // source match result
   // ----------------------------------------
   // disabled entries are invisible, so software may rewrite them safely
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         matchedEntryIndex <= NO_MATCH;
         pendingMatch <= 1'b0;
      end else begin
         matchedEntryIndex <= firstHit(shortHit & shortEn_r, extHit & extEn_r);
         pendingMatch <= |(shortHit & shortEn_r & shortPend_r) || |(extHit & extEn_r & extPend_r);
      end
   end

   // ----------------------------------------
   // receive path
   // ----------------------------------------
   logic [15:0] rxCrc_r;
   logic rxFirst_r;
   logic [7:0] hold_r;
   logic holdValid_r;
   logic stat2_r;
   logic [7:0] stat2Byte_r;
   logic [15:0] rxCrcNow;
   logic rxGood;
   logic [6:0] selLow;

   assign rxCrcNow = rxFirst_r ? CRC_INIT : crcNext(rxCrc_r, rxData);
   assign rxGood = (rxCrcNow == CRC_RESIDUE);
   assign selLow = appendSel ? matchedEntryIndex : correlation;

   // length byte is not covered by the checksum
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rxCrc_r <= CRC_INIT;
         rxFirst_r <= 1'b1;
      end else if (rxValid) begin
         rxCrc_r <= rxCrcNow;
         rxFirst_r <= rxLast;
      end
   end

   // one byte held back so the checksum bytes can be swapped for status
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         queueValid <= 1'b0;
         queueData <= 8'h00;
         hold_r <= 8'h00;
         holdValid_r <= 1'b0;
         stat2_r <= 1'b0;
         stat2Byte_r <= 8'h00;
      end else begin
         queueValid <= 1'b0;
         stat2_r <= 1'b0;
         if (stat2_r) begin
            queueValid <= 1'b1;
            queueData <= stat2Byte_r;
         end
         if (rxValid) begin
            if (!auto_checksum_enable) begin
               queueValid <= 1'b1;
               queueData <= rxData;
               holdValid_r <= 1'b0;
            end else if (rxLast) begin
               queueValid <= 1'b1;
               queueData <= rssi;
               stat2_r <= 1'b1;
               stat2Byte_r <= {rxGood, selLow};
               holdValid_r <= 1'b0;
            end else begin
               queueValid <= holdValid_r || stat2_r;
               if (holdValid_r) queueData <= hold_r;
               hold_r <= rxData;
               holdValid_r <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // auto acknowledge
   // ----------------------------------------
   logic [ACK_W-1:0] ackCnt_r;
   logic ackCause;

   // independent of the checksum setting
   assign ackCause = rxValid && rxLast && autoAck && addrAccepted && ackRequested && rxGood;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ackCnt_r <= '0;
         ackSend <= 1'b0;
      end else begin
         ackSend <= 1'b0;
         if (ackCause) begin
            ackCnt_r <= ACK_W'(ACK_DELAY);
         end else if (ackCnt_r == ACK_W'(1)) begin
            ackCnt_r <= '0;
            ackSend <= 1'b1;
         end else if (ackCnt_r != '0) begin
            ackCnt_r <= ackCnt_r - ACK_W'(1);
         end
      end
   end

   // ----------------------------------------
   // transmit path
   // ----------------------------------------
   tx_state_type txState;
   logic [15:0] txCrc_r;
   logic txFirst_r;
   logic [7:0] txLen_r;
   logic [7:0] txCount_r;
   logic txDone_r;
   logic txFire;
   logic [8:0] txNeed;
   logic [8:0] txGot;
   logic txShort;

   assign txBufReady = (txState == TX_PASS);
   assign txFire = txBufValid && txBufReady;
   assign txNeed = auto_checksum_enable ? ({1'b0, txLen_r} - FCS_BYTES) : {1'b0, txLen_r};
   assign txGot = txFirst_r ? 9'h000 : ({1'b0, txCount_r} + 9'h001);
   assign txShort = txGot < txNeed;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         txCrc_r <= CRC_INIT;
      end else if (txFire) begin
         txCrc_r <= txFirst_r ? CRC_INIT : crcNext(txCrc_r, txBufData);
      end
   end

   // an underflowing frame is cut, so no checksum follows it
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         txState <= TX_PASS;
         airValid <= 1'b0;
         airData <= 8'h00;
         txFirst_r <= 1'b1;
         txLen_r <= 8'h00;
         txCount_r <= 8'h00;
         txUnderflow <= 1'b0;
         txDone_r <= 1'b0;
      end else begin
         airValid <= 1'b0;
         txUnderflow <= 1'b0;
         txDone_r <= 1'b0;
         case (txState)
            TX_PASS: begin
               if (txFire) begin
                  airValid <= 1'b1;
                  airData <= txBufData;
                  txFirst_r <= txBufLast;
                  if (txFirst_r) begin
                     txLen_r <= txBufData;
                     txCount_r <= 8'h00;
                  end else begin
                     txCount_r <= txCount_r + 8'h01;
                  end
                  if (txBufLast) begin
                     if (txShort) txUnderflow <= 1'b1;
                     else if (auto_checksum_enable) txState <= TX_CRC_LO;
                     else txDone_r <= 1'b1;
                  end
               end
            end
            TX_CRC_LO: begin
               airValid <= 1'b1;
               airData <= txCrc_r[7:0];
               txState <= TX_CRC_HI;
            end
            TX_CRC_HI: begin
               airValid <= 1'b1;
               airData <= txCrc_r[15:8];
               txState <= TX_PASS;
               txDone_r <= 1'b1;
            end
            default: txState <= TX_PASS;
         endcase
      end
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   logic [NUM_EV-1:0] events;
   logic [NUM_EV-1:0] clearMask;

   always_comb begin
      events = '0;
      events[EV_RX_DONE] = rxValid && rxLast;
      events[EV_TX_DONE] = txDone_r;
      events[EV_TX_UNDERFLOW] = txUnderflow;
      events[EV_ACK_SENT] = ackSend;
   end

   assign clearMask = (doWrite && wrIdx == IDX_IRQ_CLEAR && lane0) ? wData_r[NUM_EV-1:0] : '0;

   // a new event wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (reset) irqStatus_r <= '0;
      else irqStatus_r <= (irqStatus_r & ~clearMask) | events;
   end

   assign irq = |(irqStatus_r & irqEnable_r);

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_extLoWrite;
      doWrite && lane0 && wrIdx == IDX_EXT_LO;
   endsequence
   sequence s_rxEndCrc;
      rxValid && rxLast && auto_checksum_enable;
   endsequence
   sequence s_txEndCrc;
      txFire && txBufLast && auto_checksum_enable && !txShort;
   endsequence

   property p_short_write;
      @(posedge sys_clk) disable iff (reset)
      doWrite && lane0 && wrIdx == IDX_SHORT_MID |=> shortEn_r[15:8] == $past(wData_r[7:0]);
   endproperty
   a_short_write: assert property (p_short_write) else $error("short enable not written");
   property p_ext_write;
      @(posedge sys_clk) disable iff (reset)
      s_extLoWrite |=> extEn_r[3:0] == {$past(wData_r[6]), $past(wData_r[4]), $past(wData_r[2]), $past(wData_r[0])};
   endproperty
   a_ext_write: assert property (p_ext_write) else $error("extended enable wrong bits");
   property p_ext_read;
      @(posedge sys_clk) disable iff (reset)
      arvalid && arready && rdIdx == IDX_EXT_MID |=> rvalid && rdata[0] == rdata[1] && rdata[6] == rdata[7];
   endproperty
   a_ext_read: assert property (p_ext_read) else $error("extended read bits differ");
   property p_pass_raw;
      @(posedge sys_clk) disable iff (reset)
      rxValid && !auto_checksum_enable |=> queueValid && queueData == $past(rxData);
   endproperty
   a_pass_raw: assert property (p_pass_raw) else $error("raw byte not queued");
   property p_status;
      @(posedge sys_clk) disable iff (reset)
      s_rxEndCrc |=> (queueValid && queueData == $past(rssi))
         ##1 (queueValid && queueData == {$past(rxGood, 2), $past(selLow, 2)});
   endproperty
   a_status: assert property (p_status) else $error("status word wrong");
   property p_tx_crc;
      @(posedge sys_clk) disable iff (reset)
      s_txEndCrc |-> ##2 (airValid && airData == txCrc_r[7:0]) ##1 (airValid && airData == txCrc_r[15:8]);
   endproperty
   a_tx_crc: assert property (p_tx_crc) else $error("checksum not appended");
   property p_underflow;
      @(posedge sys_clk) disable iff (reset)
      txFire && txBufLast && txShort |=> txUnderflow && txState == TX_PASS ##1 !txUnderflow;
   endproperty
   a_underflow: assert property (p_underflow) else $error("underflow not flagged");
   property p_ack_arm;
      @(posedge sys_clk) disable iff (reset)
      ackCause |=> ackCnt_r == ACK_W'(ACK_DELAY) && !ackSend;
   endproperty
   a_ack_arm: assert property (p_ack_arm) else $error("acknowledge delay not loaded");
   property p_ack_fire;
      @(posedge sys_clk) disable iff (reset)
      ackSend |-> $past(ackCnt_r) == ACK_W'(1);
   endproperty
   a_ack_fire: assert property (p_ack_fire) else $error("acknowledge at wrong time");
   property p_pending;
      @(posedge sys_clk) disable iff (reset)
      pendingMatch |-> $past(|(shortHit & shortEn_r & shortPend_r) || |(extHit & extEn_r & extPend_r));
   endproperty
   a_pending: assert property (p_pending) else $error("pending without enabled hit");
endmodule : frame_crc_ack_srcmatch_ctrl
`default_nettype wire

// ### modem_model.sv
// radio modem model: feeds received frames into the block
`timescale 1ns/10ps
`default_nettype none
module modem_model (
   input wire logic sys_clk,
   output logic [7:0] rxData,
   output logic rxValid,
   output logic rxLast,
   output logic [7:0] rssi,
   output logic [6:0] correlation
);
   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
      rxLast = 1'b0;
      rssi = 8'h5A;
      correlation = 7'h33;
   end
   // ----------
   // frame check sequence, low bit first
   // ----------
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'h0000;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
         end
      end
      return c;
   endfunction : crc16
   task automatic send(input logic [7:0] p[$], input logic bad);
      logic [15:0] c;
      c = crc16(p) ^ {15'h0000, bad};
      p.push_front(8'(p.size() + 2));
      p.push_back(c[7:0]);
      p.push_back(c[15:8]);
      foreach (p[i]) begin
         @(posedge sys_clk);
         rxData <= p[i];
         rxValid <= 1'b1;
         rxLast <= (i == p.size() - 1);
      end
      @(posedge sys_clk);
      rxValid <= 1'b0;
      rxLast <= 1'b0;
      // released line must not look like a stale byte
      rxData <= ~rxData;
   endtask : send
endmodule : modem_model
`default_nettype wire

// ### tb_frame_crc_ack_srcmatch_ctrl.sv
// testbench for the frame checksum, ack and source-match block
`timescale 1ns/10ps
`default_nettype none
module tb_frame_crc_ack_srcmatch_ctrl;
   import frame_ctrl_pkg::*;
   localparam int AD = 20;
   typedef struct packed {logic [15:0] idx; logic [7:0] rst, w, x;} reg_row_type;
   typedef struct packed {logic [7:0] ctrl; logic bad;} rx_row_type;
   logic sys_clk, reset, awvalid, wvalid, bready, arvalid, rready, addrAccepted, ackRequested;
   logic txBufValid, txBufLast, awready, wready, bvalid, arready, rvalid, irq, queueValid, pendingMatch;
   logic txBufReady, airValid, txUnderflow, ackSend, rxValid, rxLast;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rdv;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rsp;
   logic [7:0] rxData, rssi, queueData, txBufData, airData;
   logic [6:0] correlation, matchedEntryIndex;
   logic [23:0] shortHit;
   logic [11:0] extHit;
   logic [7:0] qCap[$], airCap[$];
   int error_cnt, checks, cyc, tLast, tAck, underCnt;
   reg_row_type regRows[7] = '{
      '{IDX_SHORT_LO, 8'h00, 8'hA5, 8'hA5}, '{IDX_SHORT_MID, 8'h00, 8'h3C, 8'h3C},
      '{IDX_SHORT_HI, 8'h00, 8'h81, 8'h81}, '{IDX_EXT_LO, 8'h00, 8'h55, 8'hFF},
      '{IDX_EXT_MID, 8'h00, 8'hAA, 8'h00}, '{IDX_EXT_HI, 8'h00, 8'h01, 8'h03},
      '{IDX_FRAME_CTRL, FRAME_CTRL_RESET, 8'hC0, 8'hC0}};
   rx_row_type rxRows[5] = '{'{8'h40, 1'b0}, '{8'hC0, 1'b0}, '{8'h40, 1'b1}, '{8'h00, 1'b0}, '{8'h80, 1'b0}};
   frame_crc_ack_srcmatch_ctrl #(.ACK_DELAY(AD)) dut (.*);
   modem_model modem (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (queueValid) qCap.push_back(queueData);
      if (airValid) airCap.push_back(airData);
      if (txUnderflow) underCnt <= underCnt + 1;
      if (rxValid && rxLast) tLast <= cyc;
      if (ackSend) tAck <= cyc;
   end
   // ----------
   // checking and bus tasks
   // ----------
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tmo(input int n);
      if (n >= 50) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask : tmo
   task automatic cmpq(input logic [7:0] got[$], input logic [7:0] exp[$]);
      chk(32'(got.size()), 32'(exp.size()));
      foreach (exp[i]) chk(got[i], exp[i]);
   endtask : cmpq
   task automatic wrReg(input logic [15:0] idx, input logic [7:0] d);
      int n;
      @(posedge sys_clk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rsp = bresp;
      bready <= 1'b0;
      tmo(n);
   endtask : wrReg
   task automatic rdReg(input logic [15:0] idx);
      int n;
      @(posedge sys_clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rdv = rdata;
      rsp = rresp;
      rready <= 1'b0;
      tmo(n);
   endtask : rdReg
   task automatic tx(input logic [7:0] p[$]);
      int n;
      @(posedge sys_clk);
      foreach (p[i]) begin
         txBufData <= p[i];
         txBufValid <= 1'b1;
         txBufLast <= (i == p.size() - 1);
         n = 0;
         @(posedge sys_clk);
         while (!txBufReady && n < 50) begin
            @(posedge sys_clk);
            n++;
         end
         tmo(n);
      end
      txBufValid <= 1'b0;
      txBufLast <= 1'b0;
   endtask : tx
   // ----------
   // main sequence
   // ----------
   initial begin
      logic [7:0] pay[$], exp[$];
      logic [15:0] c;
      int t0;
      {reset, wstrb, addrAccepted, ackRequested} = 7'h7F;
      {awvalid, wvalid, bready, arvalid, rready, txBufValid, txBufLast} = 7'h00;
      {awaddr, araddr, wdata, txBufData, extHit} = '0;
      {shortHit, extHit} = 36'h000020001;
      {error_cnt, checks, cyc, tLast, tAck, underCnt} = '0;
      pay = '{8'h11, 8'h22, 8'h33};
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      foreach (regRows[i]) begin
         rdReg(regRows[i].idx);
         chk(rdv, {24'h0, regRows[i].rst});
         wrReg(regRows[i].idx, regRows[i].w);
         rdReg(regRows[i].idx);
         chk(rdv, {24'h0, regRows[i].x});
      end
      chk(matchedEntryIndex, 7'h05);
      wrReg(IDX_SHORT_PEND, 8'h20);
      repeat (2) @(posedge sys_clk);
      chk(pendingMatch, 1'b1);
      wrReg(IDX_SHORT_LO, 8'h85);
      repeat (2) @(posedge sys_clk);
      chk(pendingMatch, 1'b0);
      chk(matchedEntryIndex, EXT_INDEX_BASE);
      wrReg(IDX_SHORT_LO, 8'hA5);
      wrReg(16'h6200, 8'h11);
      chk(rsp, RESP_SLVERR);
      rdReg(16'h6200);
      chk({rsp, rdv[29:0]}, {RESP_SLVERR, 30'h0});
      wrReg(IDX_IRQ_CLEAR, 8'h0F);
      wrReg(IDX_IRQ_ENABLE, 8'h01);
      foreach (rxRows[i]) begin
         wrReg(IDX_FRAME_CTRL, rxRows[i].ctrl);
         qCap.delete();
         modem.send(pay, rxRows[i].bad);
         repeat (4) @(posedge sys_clk);
         exp = pay;
         exp.push_front(8'h05);
         c = modem.crc16(pay) ^ {15'h0, rxRows[i].bad};
         if (rxRows[i].ctrl[6]) begin
            exp.push_back(rssi);
            exp.push_back({~rxRows[i].bad, rxRows[i].ctrl[7] ? 7'h05 : correlation});
         end else begin
            exp.push_back(c[7:0]);
            exp.push_back(c[15:8]);
         end
         cmpq(qCap, exp);
      end
      chk(irq, 1'b1);
      wrReg(IDX_IRQ_ENABLE, 8'h00);
      chk(irq, 1'b0);
      rdReg(IDX_IRQ_STATUS);
      chk(rdv, 32'h1);
      wrReg(IDX_IRQ_CLEAR, 8'h0F);
      rdReg(IDX_IRQ_STATUS);
      chk(rdv, 32'h0);
      foreach (rxRows[i]) begin
         // checksum on and off must give the same ack timing
         wrReg(IDX_FRAME_CTRL, {1'b0, ~rxRows[i].ctrl[6], 6'h20});
         t0 = tAck;
         modem.send(pay, rxRows[i].bad);
         repeat (AD + 8) @(posedge sys_clk);
         chk(tAck - (rxRows[i].bad ? t0 : tLast), rxRows[i].bad ? 0 : AD + 1);
      end
      wrReg(IDX_FRAME_CTRL, 8'h40);
      airCap.delete();
      tx('{8'h04, 8'hA1, 8'hB2});
      repeat (6) @(posedge sys_clk);
      c = modem.crc16('{8'hA1, 8'hB2});
      cmpq(airCap, '{8'h04, 8'hA1, 8'hB2, c[7:0], c[15:8]});
      wrReg(IDX_FRAME_CTRL, 8'h00);
      t0 = underCnt;
      tx('{8'h04, 8'hA1, 8'hB2});
      repeat (4) @(posedge sys_clk);
      chk(underCnt - t0, 1);
      airCap.delete();
      // software supplies the last two bytes itself here
      tx('{8'h04, 8'hA1, 8'hB2, 8'hC3, 8'hD4});
      repeat (4) @(posedge sys_clk);
      cmpq(airCap, '{8'h04, 8'hA1, 8'hB2, 8'hC3, 8'hD4});
      chk(underCnt - t0, 1);
      tally_and_finish();
   end
endmodule : tb_frame_crc_ack_srcmatch_ctrl
`default_nettype wire
